// ### pkg/nan_prop_pkg.sv
// Constants, field layout and helper functions for NaN propagation.
package nan_prop_pkg;

	// Single-precision word layout.
	localparam int WIDTH      = 32;
	localparam int SIGN_BIT   = 31;
	localparam int EXP_MSB    = 30;
	localparam int EXP_LSB    = 23;
	localparam int FRAC_MSB   = 22;
	localparam int FRAC_LSB   = 0;
	localparam int QUIET_BIT  = 22;
	localparam int EXP_W      = EXP_MSB - EXP_LSB + 1;
	localparam int FRAC_W     = FRAC_MSB - FRAC_LSB + 1;

	// Largest biased exponent, 255 in decimal, marks NaN and infinity.
	localparam logic [EXP_W-1:0]  EXP_MAX   = 8'hFF;
	localparam logic [FRAC_W-1:0] FRAC_ZERO = 23'h000000;

	// Indefinite value: sign set, exponent all ones, only quiet bit set.
	localparam logic [WIDTH-1:0]  INDEFINITE = 32'hFFC00000;

	// Reset values of the result and flag registers.
	localparam logic [WIDTH-1:0]  RESULT_RST = 32'h00000000;
	localparam logic              FLAG_RST   = 1'h0;

	// True when the exponent is all ones and the fraction is non-zero.
	function automatic logic f_is_nan(input logic [WIDTH-1:0] v);
		return (v[EXP_MSB:EXP_LSB] == EXP_MAX) &&
		       (v[FRAC_MSB:FRAC_LSB] != FRAC_ZERO);
	endfunction

	// Quiet NaN: the top fraction bit is one.
	function automatic logic f_is_qnan(input logic [WIDTH-1:0] v);
		return f_is_nan(v) && v[QUIET_BIT];
	endfunction

	// Force the quiet bit; every other bit is kept as it was.
	function automatic logic [WIDTH-1:0] f_quiet(
		input logic [WIDTH-1:0] v);
		logic [WIDTH-1:0] q;
		q = v;
		q[QUIET_BIT] = 1'h1;
		return q;
	endfunction

endpackage : nan_prop_pkg

// ### src/nan_classify.sv
// Operand classifier: NaN, quiet NaN and signaling NaN detection.
module nan_classify (
	input  wire logic [nan_prop_pkg::WIDTH-1:0] i_val,
	output logic                                o_nan,
	output logic                                o_qnan,
	output logic                                o_snan
);

	// The sign bit takes no part in the class decision.
	assign o_nan  = nan_prop_pkg::f_is_nan(i_val);
	assign o_qnan = nan_prop_pkg::f_is_qnan(i_val);
	assign o_snan = o_nan && !i_val[nan_prop_pkg::QUIET_BIT];

endmodule // nan_classify

// ### src/nan_propagation_unit.sv
// NaN propagation unit: picks the NaN result and raises invalid events.
// Summary of operation
// - NaN: exponent all ones, fraction non-zero, sign ignored.
// - Top fraction bit one marks quiet, zero marks signaling.
// - Quiet NaN operands pass through and raise no exception.
// - A signaling NaN operand raises the invalid condition.
// - No result ever leaves as a signaling NaN.
// - Unmasked invalid with signaling NaN blocks destination write.
// - Quieting sets only the top fraction bit.
// - Masked invalid sets the flag and delivers the selected NaN.
// - Invalid operation without NaN operands gives indefinite.
// - Signaling plus quiet: stack picks quiet, SIMD picks first.
// - Two signaling: stack larger significand, SIMD first, quieted.
// - Two quiet: stack larger significand, SIMD first operand.
// - Signaling NaN with a number returns that NaN quieted.
// - Quiet NaN with a number returns that NaN unchanged.
// - One-operand op returns its NaN, quieted if signaling.
// - Truncating integer store selects like the stack unit.
// - Unmasked invalid raises an exception request to the handler.
// - One indefinite quiet NaN encoding per precision.
// - All-ones exponent equals 255 for single precision.
// - NaN results bypass rounding, whatever the rounding mode.
module nan_propagation_unit (
	input  logic                           I_CLK,
	input  logic                           I_ARST_N,
	input  logic                           I_VALID,
	input  logic [nan_prop_pkg::WIDTH-1:0] I_OP_A,
	input  logic [nan_prop_pkg::WIDTH-1:0] I_OP_B,
	input  logic                           I_TWO_OPS,
	input  logic                           I_SIMD,
	input  logic                           I_TRUNC_INT_STORE,
	input  logic                           I_INVALID_OP,
	input  logic [nan_prop_pkg::WIDTH-1:0] I_ARITH_RES,
	input  logic                           I_INVALID_MASK,
	input  logic                           I_FLAG_CLR,
	output logic                           O_VALID,
	output logic [nan_prop_pkg::WIDTH-1:0] O_RESULT,
	output logic                           O_WRITE_EN,
	output logic                           O_ROUND_BYPASS,
	output logic                           O_INVALID_ARITH_OPERAND_EXCEPTION,
	output logic                           O_INVALID_FLAG
);

	localparam int W = nan_prop_pkg::WIDTH;
	localparam int FM = nan_prop_pkg::FRAC_MSB;
	localparam int FL = nan_prop_pkg::FRAC_LSB;

	logic [W-1:0] ops [2];
	logic [1:0]   is_nan;
	logic [1:0]   is_qnan;
	logic [1:0]   is_snan;
	logic         nan_b_used;
	logic         snan_b_used;
	logic         any_nan;
	logic         any_snan;
	logic         invalid_evt;
	logic         exc_nxt;
	logic         first_style;
	logic [W-1:0] pick;
	logic [W-1:0] result_nxt;
	logic         valid_r;
	logic         write_r;
	logic         exc_r;
	logic         bypass_r;
	logic         flag_r;
	logic [W-1:0] result_r;

	assign ops[0] = I_OP_A;
	assign ops[1] = I_OP_B;

	// One classifier per operand; the second one is ignored on unary ops.
	generate
		for (genvar g = 0; g < 2; g++) begin : g_cls
			nan_classify u_cls (
				.i_val  (ops[g]),
				.o_nan  (is_nan[g]),
				.o_qnan (is_qnan[g]),
				.o_snan (is_snan[g])
			);
		end
	endgenerate

	// Operand B only counts when the operation really takes two operands.
	assign nan_b_used  = I_TWO_OPS && is_nan[1];
	assign snan_b_used = I_TWO_OPS && is_snan[1];
	assign any_nan     = is_nan[0] || nan_b_used;
	assign any_snan    = is_snan[0] || snan_b_used;

	// The truncating store follows the stack unit even though it is SIMD.
	assign first_style = I_SIMD && !I_TRUNC_INT_STORE;

	// Quiet NaNs alone never make the operation invalid.
	assign invalid_evt = any_snan || I_INVALID_OP;
	assign exc_nxt     = I_VALID && invalid_evt && !I_INVALID_MASK;

	// NaN operand selection, before quieting.
	always_comb begin
		pick = I_OP_A;
		if (!I_TWO_OPS || !nan_b_used) begin
			pick = I_OP_A;
		end else if (!is_nan[0]) begin
			pick = I_OP_B;
		end else if (first_style) begin
			pick = I_OP_A;
		end else if (is_snan[0] != is_snan[1]) begin
			pick = is_snan[0] ? I_OP_B : I_OP_A;
		end else if (I_OP_B[FM:FL] > I_OP_A[FM:FL]) begin
			pick = I_OP_B;
		end else begin
			pick = I_OP_A;
		end
	end

	// Final result. Payload bits are carried untouched; only the quiet bit
	// is forced, so no NaN of any origin can leave as signaling.
	always_comb begin
		if (any_nan) begin
			result_nxt = nan_prop_pkg::f_quiet(pick);
		end else if (I_INVALID_OP) begin
			result_nxt = nan_prop_pkg::INDEFINITE;
		end else if (nan_prop_pkg::f_is_nan(I_ARITH_RES)) begin
			result_nxt = nan_prop_pkg::f_quiet(I_ARITH_RES);
		end else begin
			result_nxt = I_ARITH_RES;
		end
	end

	// Handshake and exception request, one cycle after the operands.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			valid_r <= 1'h0;
			write_r <= 1'h0;
			exc_r   <= 1'h0;
		end else begin
			valid_r <= I_VALID;
			write_r <= I_VALID && !exc_nxt;
			exc_r   <= exc_nxt;
		end
	end

	// Result register; it holds its value while no operation is valid.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			result_r <= nan_prop_pkg::RESULT_RST;
		end else if (I_VALID) begin
			result_r <= result_nxt;
		end
	end

	// A NaN result skips rounding, so the rounder is told to stand aside.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bypass_r <= 1'h0;
		end else begin
			bypass_r <= I_VALID &&
			            nan_prop_pkg::f_is_nan(result_nxt);
		end
	end

	// Sticky invalid flag. A new event in the clearing cycle wins, so
	// software never loses an event that raced its own clear.
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			flag_r <= nan_prop_pkg::FLAG_RST;
		end else if (I_VALID && invalid_evt) begin
			flag_r <= 1'h1;
		end else if (I_FLAG_CLR) begin
			flag_r <= 1'h0;
		end
	end

	assign O_VALID        = valid_r;
	assign O_RESULT       = result_r;
	assign O_WRITE_EN     = write_r;
	assign O_ROUND_BYPASS = bypass_r;
	assign O_INVALID_ARITH_OPERAND_EXCEPTION = exc_r;
	assign O_INVALID_FLAG = flag_r;

	// Checks on the unit's own outputs.
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	property p_no_snan_out;
		O_VALID |-> !(nan_prop_pkg::f_is_nan(O_RESULT) &&
		              !O_RESULT[nan_prop_pkg::QUIET_BIT]);
	endproperty
	a_no_snan_out: assert property (p_no_snan_out)
		else $error("signaling NaN delivered as result");

	property p_unmasked_trap;
		I_VALID && any_snan && !I_INVALID_MASK |=>
			O_VALID && !O_WRITE_EN && O_INVALID_ARITH_OPERAND_EXCEPTION;
	endproperty
	a_unmasked_trap: assert property (p_unmasked_trap)
		else $error("unmasked signaling NaN did not trap");

	property p_exc_one_cycle;
		I_VALID && invalid_evt && !I_INVALID_MASK ##1 !I_VALID |=>
			!O_INVALID_ARITH_OPERAND_EXCEPTION;
	endproperty
	a_exc_one_cycle: assert property (p_exc_one_cycle)
		else $error("exception request longer than its operation");

	property p_masked_flag;
		I_VALID && any_snan && I_INVALID_MASK |=>
			O_INVALID_FLAG && O_WRITE_EN &&
			!O_INVALID_ARITH_OPERAND_EXCEPTION;
	endproperty
	a_masked_flag: assert property (p_masked_flag)
		else $error("masked signaling NaN handled wrongly");

	property p_qnan_pass;
		I_VALID && I_TWO_OPS && is_qnan[0] && !is_nan[1] &&
		!I_INVALID_OP |=>
			O_RESULT == $past(I_OP_A) &&
			!O_INVALID_ARITH_OPERAND_EXCEPTION;
	endproperty
	a_qnan_pass: assert property (p_qnan_pass)
		else $error("quiet NaN with number not passed unchanged");

	property p_snan_quieted;
		I_VALID && I_TWO_OPS && is_snan[0] && !is_nan[1] |=>
			O_RESULT == nan_prop_pkg::f_quiet($past(I_OP_A));
	endproperty
	a_snan_quieted: assert property (p_snan_quieted)
		else $error("signaling NaN with number not quieted");

	property p_first_style;
		I_VALID && I_TWO_OPS && I_SIMD && !I_TRUNC_INT_STORE &&
		is_nan[0] && is_nan[1] |=>
			O_RESULT == nan_prop_pkg::f_quiet($past(I_OP_A));
	endproperty
	a_first_style: assert property (p_first_style)
		else $error("SIMD style did not return first operand");

	property p_stack_larger;
		I_VALID && I_TWO_OPS && (!I_SIMD || I_TRUNC_INT_STORE) &&
		is_qnan[0] && is_qnan[1] && I_OP_B[FM:FL] > I_OP_A[FM:FL] |=>
			O_RESULT == $past(I_OP_B);
	endproperty
	a_stack_larger: assert property (p_stack_larger)
		else $error("stack style missed larger significand");

	property p_indefinite;
		I_VALID && !any_nan && I_INVALID_OP |=>
			O_RESULT == nan_prop_pkg::INDEFINITE && O_ROUND_BYPASS;
	endproperty
	a_indefinite: assert property (p_indefinite)
		else $error("invalid operation without NaN not indefinite");

	property p_flag_sticky;
		O_INVALID_FLAG && !I_FLAG_CLR |=> O_INVALID_FLAG;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("invalid flag dropped without a clear");

	property p_bypass;
		O_VALID && nan_prop_pkg::f_is_nan(O_RESULT) |-> O_ROUND_BYPASS;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("NaN result not marked for rounding bypass");

	// Quiet operands and valid numbers in a valid operation never trap and always write.
	property p_quiet_no_trap;
		I_VALID && !any_snan && !I_INVALID_OP |=>
			O_WRITE_EN && !O_INVALID_ARITH_OPERAND_EXCEPTION;
	endproperty
	a_quiet_no_trap: assert property (p_quiet_no_trap)
		else $error("quiet operation trapped or lost its write");

	// Any signaling operand leaves the flag set behind it.
	property p_snan_sets_flag;
		I_VALID && any_snan |=> O_INVALID_FLAG;
	endproperty
	a_snan_sets_flag: assert property (p_snan_sets_flag)
		else $error("signaling NaN did not set the invalid flag");

	// A one-operand NaN comes back quieted; operand B plays no part.
	property p_unary_nan;
		I_VALID && !I_TWO_OPS && is_nan[0] |=>
			O_RESULT == nan_prop_pkg::f_quiet($past(I_OP_A));
	endproperty
	a_unary_nan: assert property (p_unary_nan)
		else $error("one-operand NaN not returned quieted");

	// Stack style with a signaling first and a quiet second operand.
	property p_stack_mixed;
		I_VALID && I_TWO_OPS && (!I_SIMD || I_TRUNC_INT_STORE) &&
		is_snan[0] && is_qnan[1] |=> O_RESULT == $past(I_OP_B);
	endproperty
	a_stack_mixed: assert property (p_stack_mixed)
		else $error("stack style did not pick the quiet NaN");

	// Two signaling operands on the stack: larger significand, quieted.
	property p_stack_two_snan;
		I_VALID && I_TWO_OPS && (!I_SIMD || I_TRUNC_INT_STORE) &&
		is_snan[0] && is_snan[1] && I_OP_B[FM:FL] > I_OP_A[FM:FL] |=>
			O_RESULT == nan_prop_pkg::f_quiet($past(I_OP_B));
	endproperty
	a_stack_two_snan: assert property (p_stack_two_snan)
		else $error("two signaling NaNs resolved wrongly");

	// The truncating store resolves like the stack even in SIMD mode.
	property p_trunc_store;
		I_VALID && I_TWO_OPS && I_SIMD && I_TRUNC_INT_STORE &&
		is_qnan[0] && is_qnan[1] && I_OP_B[FM:FL] > I_OP_A[FM:FL] |=>
			O_RESULT == $past(I_OP_B);
	endproperty
	a_trunc_store: assert property (p_trunc_store)
		else $error("truncating store did not use stack selection");

	// A write strobe only ever rides on an answer.
	property p_write_with_valid;
		O_WRITE_EN |-> O_VALID;
	endproperty
	a_write_with_valid: assert property (p_write_with_valid)
		else $error("destination write without an answer");

	// An event in the clearing cycle wins over the clear.
	property p_flag_set_wins;
		I_VALID && invalid_evt && I_FLAG_CLR |=> O_INVALID_FLAG;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins)
		else $error("invalid flag lost an event to its clear");

	// A clear with no event in the same cycle drops the flag.
	property p_flag_clear;
		I_FLAG_CLR && !(I_VALID && invalid_evt) |=> !O_INVALID_FLAG;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("invalid flag ignored its clear");

	// An ordinary result is delivered as computed and goes to rounding.
	property p_number_pass;
		I_VALID && !any_nan && !I_INVALID_OP &&
		!nan_prop_pkg::f_is_nan(I_ARITH_RES) |=>
			O_RESULT == $past(I_ARITH_RES) && !O_ROUND_BYPASS;
	endproperty
	a_number_pass: assert property (p_number_pass)
		else $error("ordinary result altered or kept from rounding");

	// Main scenarios worth seeing in simulation.
	c_trap: cover property (I_VALID && any_snan && !I_INVALID_MASK);
	c_two_snan_stack: cover property (
		I_VALID && I_TWO_OPS && !I_SIMD && is_snan[0] && is_snan[1]);
	c_trunc_store: cover property (
		I_VALID && I_SIMD && I_TRUNC_INT_STORE && is_nan[0] && is_nan[1]);
	c_clear_race: cover property (
		I_VALID && invalid_evt && I_FLAG_CLR);

endmodule // nan_propagation_unit

// ### verif/fp_pipe_model.sv
// Operand source that stands in for the floating-point execution pipeline.
module fp_pipe_model (
	input  wire logic        i_clk,
	output logic             o_valid,
	output logic [31:0]      o_a,
	output logic [31:0]      o_b,
	output logic [31:0]      o_arith,
	output logic [5:0]       o_ctl
);
	timeunit 1ns;
	timeprecision 1ps;

	// Nothing is requested at time zero, so reset sees a quiet source.
	initial begin
		o_valid = 1'h0;
		o_a = 32'h00000000;
		o_b = 32'h00000000;
		o_arith = 32'h00000000;
		o_ctl = 6'h00;
	end

	// One request per falling edge; NaN payload bits are the caller's own.
	task automatic issue(input logic [31:0] a, b, r, input logic [5:0] c);
		@(negedge i_clk);
		o_valid = 1'h1;
		o_a = a;
		o_b = b;
		o_arith = r;
		o_ctl = c;
	endtask

	// A released operand bus shows the inverse of its last value, so a
	// unit that samples it outside a request delivers visibly wrong data.
	task automatic idle();
		@(negedge i_clk);
		o_valid = 1'h0;
		o_a = ~o_a;
		o_b = ~o_b;
		o_arith = ~o_arith;
		o_ctl[0] = 1'h0;
	endtask
endmodule // fp_pipe_model

// ### verif/tb.sv
// Self-checking bench for the NaN propagation unit.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'h0;
	logic        arst_n = 1'h0;
	logic        v, ov, wen, byp, exc, flg;
	logic [31:0] a, b, ar, res;
	logic [5:0]  ctl;
	logic [31:0] seed = 32'h00005E38;
	logic        flag_m = 1'h0;
	logic [35:0] expq[$];
	logic [35:0] e;
	int          errors = 0;
	int          checked = 0;

	// Clock at 20 MHz.
	always #25 clk = ~clk;

	fp_pipe_model FEP (.i_clk(clk), .o_valid(v), .o_a(a), .o_b(b),
		.o_arith(ar), .o_ctl(ctl));

	nan_propagation_unit DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_VALID(v),
		.I_OP_A(a), .I_OP_B(b), .I_TWO_OPS(ctl[5]), .I_SIMD(ctl[4]),
		.I_TRUNC_INT_STORE(ctl[3]), .I_INVALID_OP(ctl[2]),
		.I_ARITH_RES(ar), .I_INVALID_MASK(ctl[1]), .I_FLAG_CLR(ctl[0]),
		.O_VALID(ov), .O_RESULT(res), .O_WRITE_EN(wen),
		.O_ROUND_BYPASS(byp), .O_INVALID_ARITH_OPERAND_EXCEPTION(exc),
		.O_INVALID_FLAG(flg));

	// Comparison with counting; unknown bits never pass.
	task automatic chk(input string n, input logic [31:0] s, x);
		checked++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask

	// Verdict and end of run, shared by the main sequence and watchdog.
	task automatic report_and_stop();
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic isnan(input logic [31:0] x);
		return x[30:23] == 8'hFF && x[22:0] != 23'h000000;
	endfunction

	// Number, quiet NaN, signaling NaN or infinity from one random word.
	function automatic logic [31:0] mk(input logic [31:0] x);
		case (x[1:0])
			2'h0: return {x[31], x[30:23] & 8'hFE, x[22:0]};
			2'h1: return {x[31], 8'hFF, 1'h1, x[21:0]};
			2'h2: return {x[31], 8'hFF, 1'h0, x[21:1], 1'h1};
			default: return {x[31], 8'hFF, 23'h000000};
		endcase
	endfunction

	// Reference model: pushes result, write, bypass, exception and flag.
	task automatic expect_op(input logic [31:0] x, y, r, input logic [5:0] c);
		logic [31:0] p;
		logic        na, nb, sa, sb, ev, ex;
		na = isnan(x);
		nb = c[5] && isnan(y);
		sa = na && !x[22];
		sb = nb && !y[22];
		p = r;
		if (na && nb && !(c[4] && !c[3])) begin
			if (sa != sb) p = sa ? y : x;
			else p = (y[22:0] > x[22:0]) ? y : x;
			p[22] = 1'h1;
		end else if (na || nb) begin
			p = na ? x : y;
			p[22] = 1'h1;
		end else if (c[2]) begin
			p = 32'hFFC00000;
		end else if (isnan(r)) begin
			p[22] = 1'h1;
		end
		ev = sa || sb || c[2];
		ex = ev && !c[1];
		flag_m = ev || (flag_m && !c[0]);
		expq.push_back({p, !ex, isnan(p), ex, flag_m});
	endtask

	// Every answer is compared against the oldest expectation.
	always @(negedge clk) begin
		if (arst_n && ov === 1'h1) begin
			if (expq.size() == 0) begin
				chk("spurious answer", 32'h1, 32'h0);
			end else begin
				e = expq.pop_front();
				if (e[3]) chk("result", res, e[35:4]);
				chk("write", wen, e[3]);
				chk("bypass", byp, e[2]);
				chk("exception", exc, e[1]);
				chk("flag", flg, e[0]);
			end
		end else if (arst_n) begin
			chk("idle pulses", {wen, byp, exc}, 32'h0);
		end
	end

	// Watchdog: about five times the cycles the sequence needs.
	initial begin
		#(2000 * 50);
		errors++;
		report_and_stop();
	end

	// Reset check, two stack ties, then a random mix with gaps.
	initial begin
		logic [31:0] x, y, r;
		logic [5:0]  c;
		repeat (4) @(posedge clk);
		chk("reset outputs", {ov, wen, byp, exc, flg}, 32'h0);
		chk("reset result", res, 32'h00000000);
		@(negedge clk) arst_n = 1'h1;
		expect_op(32'h7F800001, 32'hFF800001, 32'h0, 6'h22);
		FEP.issue(32'h7F800001, 32'hFF800001, 32'h0, 6'h22);
		expect_op(32'h7FC00005, 32'hFFC00005, 32'h0, 6'h2B);
		FEP.issue(32'h7FC00005, 32'hFFC00005, 32'h0, 6'h2B);
		for (int i = 0; i < 400; i++) begin
			seed = lfsr(seed);
			x = mk(seed);
			seed = lfsr(seed);
			y = mk(seed >> 3);
			r = mk(seed >> 7);
			seed = lfsr(seed);
			c = {seed[5:3], seed[11] & seed[12], seed[1],
				seed[6] & seed[7] & seed[10]};
			if (seed[9:8] == 2'h0) begin
				FEP.idle();
			end else begin
				expect_op(x, y, r, c);
				FEP.issue(x, y, r, c);
			end
		end
		repeat (4) FEP.idle();
		chk("left over", expq.size(), 32'h0);
		report_and_stop();
	end
endmodule // tb
